// file: fdtc_defines.svh
// constants for the drive timing, configure and relative seek block
`ifndef FDTC_DEFINES_SVH
`define FDTC_DEFINES_SVH
`define FDTC_OFS_TIMING  5'h00
`define FDTC_OFS_CONFIG  5'h04
`define FDTC_OFS_RATE    5'h08
`define FDTC_OFS_CMD     5'h0C
`define FDTC_OFS_XFER    5'h10
`define FDTC_OFS_STATUS  5'h14
`define FDTC_OFS_VERSION 5'h18
`define FDTC_HUT_LSB     0
`define FDTC_SRT_LSB     4
`define FDTC_HLT_LSB     8
`define FDTC_ND_BIT      15
`define FDTC_EIS_BIT     0
`define FDTC_FDIS_BIT    1
`define FDTC_PDIS_BIT    2
`define FDTC_THR_LSB     4
`define FDTC_PRE_LSB     8
`define FDTC_TIMING_RST  16'h0000
`define FDTC_CONFIG_RST  16'h0002
`define FDTC_RATE_500K   3'h0
`define FDTC_RATE_300K   3'h1
`define FDTC_RATE_250K   3'h2
`define FDTC_RATE_1M     3'h3
`define FDTC_RATE_2M     3'h4
`define FDTC_OPC_SEEK_LO 4'hF
`define FDTC_OPC_RECAL   8'h07
`define FDTC_CLK_MHZ     100
`define FDTC_UNIT_500K_US 1000
`define FDTC_STEP_PULSE_NS 1000
`define FDTC_STEP_PULSE_CYC (`FDTC_STEP_PULSE_NS * `FDTC_CLK_MHZ / 1000)
`define FDTC_SRT_BASE    5'h10
`define FDTC_HUT_MULT    5'h10
`define FDTC_HLT_MULT    5'h02
`define FDTC_RECAL_MAX   8'h50
`endif

// file: fdtc_pkg.sv
// types and shared arithmetic of the drive timing block
package fdtc_pkg;
`include "fdtc_defines.svh"
   typedef enum logic [1:0] {S_IDLE, S_EVAL, S_WAIT, S_PULSE} fdtc_seek_t;
   typedef enum logic [1:0] {X_IDLE, X_SEEK, X_LOAD, X_EXEC} fdtc_xfer_t;
   typedef enum logic [1:0] {OP_SEEK, OP_REL, OP_RECAL} fdtc_op_t;

   // code zero means the longest interval, 256 units
   function automatic logic [8:0] code_units(input logic [6:0] code,
                                             input logic [4:0] mult);
      logic [11:0] p;
      p = code * mult;
      return (code == 7'h00) ? 9'h100 : p[8:0];
   endfunction

   // one timer unit is 1 ms at 500 kbps, scaled by the rate
   function automatic int unsigned unit_period(input logic [2:0] rate,
                                               input int unsigned base);
      case (rate)
         `FDTC_RATE_2M:   return base / 4;
         `FDTC_RATE_1M:   return base / 2;
         `FDTC_RATE_300K: return base * 5 / 3;
         `FDTC_RATE_250K: return base * 2;
         default:         return base;
      endcase
   endfunction
endpackage

// file: fdtc_tick.sv
// timer unit divider, one-cycle tick per unit at the chosen rate
`timescale 1ns/100ps
module fdtc_tick #(
   parameter int unsigned UNIT_CYC = 100000
) (
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic [2:0] rate,
   output logic            tick
);
   logic [31:0] cnt_reg;
   wire  [31:0] period = fdtc_pkg::unit_period(rate, UNIT_CYC);
   wire         wrap   = (cnt_reg >= period - 32'h0000_0001);

   // rate change applies to the running count at once; a shorter period can end the current unit early
   always_ff @(posedge clk)
   begin
      if (srst || wrap)
         cnt_reg <= 32'h0000_0000;
      else
         cnt_reg <= cnt_reg + 32'h0000_0001;
      tick <= !srst && wrap;
   end
endmodule

// file: fdtc_sync.sv
// two-stage synchroniser for a drive pin
`timescale 1ns/100ps
module fdtc_sync (
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic din,
   output logic      dout
);
   logic meta_reg;

   // first stage feeds only the second
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         meta_reg <= 1'b0;
         dout     <= 1'b0;
      end
      else
      begin
         meta_reg <= din;
         dout     <= meta_reg;
      end
   end
endmodule

// file: fdtc_top.sv
// drive timing, configure, version and seek engine with Avalon slave
//
// Chosen here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "fdtc_defines.svh"
module fdtc_top #(
   parameter int unsigned UNIT_500K_CYC = `FDTC_UNIT_500K_US * `FDTC_CLK_MHZ,
   parameter logic [7:0]  VERSION_BYTE  = 8'h5A // arbitrary value
) (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        track_zero_input,
   output logic             step_out,
   output logic             direction_out,
   output logic             head_load_out,
   output logic             disk_dma_request,
   output logic             request_for_master,
   output logic             disk_interrupt_out
);
   localparam logic [6:0] PULSE_CYC = 7'(`FDTC_STEP_PULSE_CYC);

   logic [15:0]          timing_reg;
   logic [15:0]          cfg_reg;
   logic [2:0]           rate_reg;
   logic [7:0]           pcn_reg;
   logic [7:0]           tgt_reg;
   logic [7:0]           steps_reg;
   logic                 dir_reg;
   logic                 imp_reg;
   logic [4:0]           cnt_reg;
   logic [6:0]           pls_reg;
   logic                 se_reg;
   logic                 ec_reg;
   logic                 int_reg;
   logic                 poll_reg;
   logic                 head_reg;
   logic [8:0]           xcnt_reg;
   logic [8:0]           hut_reg;
   logic                 xreq_reg;
   logic [4:0]           burst_reg;
   logic                 tick;
   logic                 trk0_s;
   fdtc_pkg::fdtc_seek_t st_reg;
   fdtc_pkg::fdtc_xfer_t xst_reg;
   fdtc_pkg::fdtc_op_t   op_reg;

   fdtc_tick #(
      .UNIT_CYC (UNIT_500K_CYC)
   ) u_tick (
      .clk  (clk),
      .srst (srst),
      .rate (rate_reg),
      .tick (tick)
   );

   fdtc_sync u_trk0 (
      .clk  (clk),
      .srst (srst),
      .din  (track_zero_input),
      .dout (trk0_s)
   );

   // bus decode: first cycle of a request, and the accepting edge
   wire acc    = (avs_read || avs_write) && avs_waitrequest;
   wire wr_go  = avs_write && !avs_waitrequest;
   wire sel_tm = avs_address == `FDTC_OFS_TIMING;
   wire sel_cf = avs_address == `FDTC_OFS_CONFIG;
   wire sel_rt = avs_address == `FDTC_OFS_RATE;
   wire sel_cm = avs_address == `FDTC_OFS_CMD;
   wire sel_xf = avs_address == `FDTC_OFS_XFER;
   wire sel_st = avs_address == `FDTC_OFS_STATUS;
   wire sel_vr = avs_address == `FDTC_OFS_VERSION;

   // field views of the stored timing and configure words
   wire [3:0] hut_code = timing_reg[`FDTC_HUT_LSB +: 4];
   wire [3:0] srt_code = timing_reg[`FDTC_SRT_LSB +: 4];
   wire [6:0] hlt_code = timing_reg[`FDTC_HLT_LSB +: 7];
   wire       nd       = timing_reg[`FDTC_ND_BIT];
   wire       implied_seek_enable      = cfg_reg[`FDTC_EIS_BIT];
   wire       fdis     = cfg_reg[`FDTC_FDIS_BIT];
   wire       pdis     = cfg_reg[`FDTC_PDIS_BIT];
   wire [3:0] thr      = cfg_reg[`FDTC_THR_LSB +: 4];
   wire [4:0] srt_u    = `FDTC_SRT_BASE - {1'b0, srt_code};
   wire [8:0] hut_u    = fdtc_pkg::code_units({3'h0, hut_code},
                                              `FDTC_HUT_MULT);
   wire [8:0] hlt_u    = fdtc_pkg::code_units(hlt_code, `FDTC_HLT_MULT);
   wire [4:0] bsize    = fdis ? 5'h01 : {1'b0, thr} + 5'h01;

   // command decode; one engine, so no second seek may start
   wire [7:0] opc     = avs_writedata[15:8];
   wire       fam     = opc[3:0] == `FDTC_OPC_SEEK_LO;
   wire       recal   = opc == `FDTC_OPC_RECAL;
   wire       sk_idle = st_reg == fdtc_pkg::S_IDLE;
   wire       cmd_go  = wr_go && sel_cm && sk_idle && (fam || recal);
   wire       xgo     = wr_go && sel_xf && avs_writedata[0] && sk_idle
                        && xst_reg == fdtc_pkg::X_IDLE;
   wire       imp_go  = xgo && implied_seek_enable;
   wire       sk_go   = cmd_go || imp_go;
   wire       xend    = wr_go && sel_xf && avs_writedata[1]
                        && xst_reg == fdtc_pkg::X_EXEC;
   wire       xack    = wr_go && sel_xf && avs_writedata[2]
                        && xst_reg == fdtc_pkg::X_EXEC && xreq_reg;
   wire       sense   = wr_go && sel_st;

   // seek termination tests, taken before each step
   wire o_seek = op_reg == fdtc_pkg::OP_SEEK;
   wire o_rel  = op_reg == fdtc_pkg::OP_REL;
   wire o_rec  = op_reg == fdtc_pkg::OP_RECAL;
   wire hit_w  = o_seek ? (pcn_reg == tgt_reg)
               : o_rel  ? (steps_reg == tgt_reg) : trk0_s;
   wire fail_w = o_rec ? (steps_reg == `FDTC_RECAL_MAX)
               : (o_rel && !dir_reg && trk0_s);
   wire in_ev  = st_reg == fdtc_pkg::S_EVAL;
   wire finish = in_ev && (hit_w || fail_w) && !imp_reg;
   wire p_end  = st_reg == fdtc_pkg::S_PULSE && pls_reg == 7'h01;
   wire w_end  = st_reg == fdtc_pkg::S_WAIT && tick && cnt_reg == 5'h01;
   wire x_ent  = xst_reg == fdtc_pkg::X_LOAD && xcnt_reg == 9'h000;
   wire poll_f = poll_reg && !pdis && !head_reg;

   // read mux; unmapped offsets read zero
   wire [31:0] rd_mux =
      sel_tm ? {16'h0000, timing_reg} :
      sel_cf ? {16'h0000, cfg_reg} :
      sel_rt ? {29'h0000_0000, rate_reg} :
      sel_cm ? {24'h00_0000, tgt_reg} :
      sel_st ? {17'h0_0000, disk_dma_request, request_for_master,
                int_reg, head_reg, ec_reg, se_reg, !sk_idle, pcn_reg} :
      sel_vr ? {24'h00_0000, VERSION_BYTE} :
      32'h0000_0000;

   // one wait cycle on every access, answer on the second
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end
      else
      begin
         avs_waitrequest <= !acc;
         if (acc)
            avs_readdata <= rd_mux;
      end
   end

   // software settings; reset gives the configure defaults
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         timing_reg <= `FDTC_TIMING_RST;
         cfg_reg    <= `FDTC_CONFIG_RST;
         rate_reg   <= `FDTC_RATE_500K;
      end
      else
      begin
         if (wr_go && sel_tm)
            timing_reg <= avs_writedata[15:0];
         if (wr_go && sel_cf)
            cfg_reg <= avs_writedata[15:0];
         if (wr_go && sel_rt)
            rate_reg <= avs_writedata[2:0];
      end
   end

   // seek engine sequencing
   always_ff @(posedge clk)
   begin
      if (srst)
         st_reg <= fdtc_pkg::S_IDLE;
      else
         case (st_reg)
            fdtc_pkg::S_IDLE:
               if (sk_go)
                  st_reg <= fdtc_pkg::S_EVAL;
            fdtc_pkg::S_EVAL:
               if (hit_w || fail_w)
                  st_reg <= fdtc_pkg::S_IDLE;
               else
                  st_reg <= fdtc_pkg::S_WAIT;
            fdtc_pkg::S_WAIT:
               if (w_end)
                  st_reg <= fdtc_pkg::S_PULSE;
            fdtc_pkg::S_PULSE:
               if (p_end)
                  st_reg <= fdtc_pkg::S_EVAL;
            default:
               st_reg <= fdtc_pkg::S_IDLE;
         endcase
   end

   // command capture; relative seek told apart by the opcode MSB
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         op_reg  <= fdtc_pkg::OP_SEEK;
         tgt_reg <= 8'h00;
         imp_reg <= 1'b0;
      end
      else if (sk_go)
      begin
         imp_reg <= imp_go;
         tgt_reg <= imp_go ? avs_writedata[15:8] : avs_writedata[7:0];
         if (recal && !imp_go)
            op_reg <= fdtc_pkg::OP_RECAL;
         else if (!imp_go && opc[7])
            op_reg <= fdtc_pkg::OP_REL;
         else
            op_reg <= fdtc_pkg::OP_SEEK;
      end
   end

   // direction: relative from opcode bit 6, seek by compare
   always_ff @(posedge clk)
   begin
      if (srst)
         dir_reg <= 1'b0;
      else if (cmd_go)
         dir_reg <= !recal && opc[7] && opc[6];
      else if (in_ev && o_seek)
         dir_reg <= tgt_reg > pcn_reg;
   end

   // cylinder counter wraps mod 256; recalibrate zeroes it
   always_ff @(posedge clk)
   begin
      if (srst)
         pcn_reg <= 8'h00;
      else if (cmd_go && recal)
         pcn_reg <= 8'h00;
      else if (p_end && !o_rec)
         pcn_reg <= dir_reg ? pcn_reg + 8'h01 : pcn_reg - 8'h01;
   end

   // pulse count, compared with the count, never with the cylinder
   always_ff @(posedge clk)
   begin
      if (srst || sk_go)
         steps_reg <= 8'h00;
      else if (p_end)
         steps_reg <= steps_reg + 8'h01;
   end

   // step spacing in units, then a fixed-width pulse
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cnt_reg <= 5'h00;
         pls_reg <= 7'h00;
      end
      else
      begin
         if (in_ev)
            cnt_reg <= srt_u;
         else if (st_reg == fdtc_pkg::S_WAIT && tick)
            cnt_reg <= cnt_reg - 5'h01;
         if (w_end)
            pls_reg <= PULSE_CYC;
         else if (st_reg == fdtc_pkg::S_PULSE)
            pls_reg <= pls_reg - 7'h01;
      end
   end

   // sticky results; a set in the clearing cycle wins
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         se_reg   <= 1'b0;
         ec_reg   <= 1'b0;
         int_reg  <= 1'b0;
         poll_reg <= 1'b1;
      end
      else
      begin
         se_reg   <= finish || (se_reg && !sense);
         ec_reg   <= (finish && !hit_w) || (ec_reg && !sense);
         int_reg  <= finish || poll_f || (int_reg && !sense);
         poll_reg <= poll_reg && !poll_f;
      end
   end

   // read/write sequence: implied seek, head load, execution
   always_ff @(posedge clk)
   begin
      if (srst)
         xst_reg <= fdtc_pkg::X_IDLE;
      else
         case (xst_reg)
            fdtc_pkg::X_IDLE:
               if (xgo)
                  xst_reg <= implied_seek_enable ? fdtc_pkg::X_SEEK
                                 : fdtc_pkg::X_LOAD;
            fdtc_pkg::X_SEEK:
               if (sk_idle)
                  xst_reg <= fdtc_pkg::X_LOAD;
            fdtc_pkg::X_LOAD:
               if (x_ent)
                  xst_reg <= fdtc_pkg::X_EXEC;
            fdtc_pkg::X_EXEC:
               if (xend)
                  xst_reg <= fdtc_pkg::X_IDLE;
            default:
               xst_reg <= fdtc_pkg::X_IDLE;
         endcase
   end

   // head timers; extra unit covers the free-running first tick
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         xcnt_reg <= 9'h000;
         hut_reg  <= 9'h000;
         head_reg <= 1'b0;
      end
      else
      begin
         if (xgo)
            xcnt_reg <= head_reg ? 9'h000 : hlt_u + 9'h001;
         else if (xst_reg == fdtc_pkg::X_LOAD && tick && xcnt_reg != 9'h000)
            xcnt_reg <= xcnt_reg - 9'h001;
         if (xend)
            hut_reg <= hut_u + 9'h001;
         else if (xgo)
            hut_reg <= 9'h000;
         else if (tick && hut_reg != 9'h000)
            hut_reg <= hut_reg - 9'h001;
         if (xst_reg == fdtc_pkg::X_LOAD)
            head_reg <= 1'b1;
         else if (tick && hut_reg == 9'h001)
            head_reg <= 1'b0;
      end
   end

   // transfer requests in bursts of the threshold plus one, one byte if off
   always_ff @(posedge clk)
   begin
      if (srst || xend)
         xreq_reg <= 1'b0;
      else if (x_ent)
         xreq_reg <= 1'b1;
      else if (xack && burst_reg == 5'h01)
         xreq_reg <= 1'b0;
      else if (xst_reg == fdtc_pkg::X_EXEC)
         xreq_reg <= 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         burst_reg <= 5'h00;
      else if (x_ent || (xack && burst_reg == 5'h01))
         burst_reg <= bsize;
      else if (xack)
         burst_reg <= burst_reg - 5'h01;
   end

   // registered pins; request goes to DMA or to master flag
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         step_out           <= 1'b0;
         direction_out      <= 1'b0;
         head_load_out      <= 1'b0;
         disk_dma_request   <= 1'b0;
         request_for_master <= 1'b0;
         disk_interrupt_out <= 1'b0;
      end
      else
      begin
         step_out           <= w_end || (st_reg == fdtc_pkg::S_PULSE
                                         && !p_end);
         direction_out      <= dir_reg;
         head_load_out      <= head_reg;
         disk_dma_request   <= xreq_reg && !nd;
         request_for_master <= xreq_reg && nd;
         disk_interrupt_out <= int_reg || (xreq_reg && nd);
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (srst);

   AST_ND_SELECT: assert property (
      (xreq_reg && nd) |=> request_for_master && !disk_dma_request)
      else $error("non-DMA mode did not use master request");
   AST_DMA_PIN: assert property (
      (xreq_reg && !nd) |=> disk_dma_request && !request_for_master)
      else $error("DMA mode did not raise DMA request");
   AST_CFG_DEFAULT: assert property (
      $past(srst) |-> cfg_reg == `FDTC_CONFIG_RST && poll_reg)
      else $error("configure defaults wrong after reset");
   AST_REL_WRAP: assert property (
      (p_end && o_rel && dir_reg) |=> pcn_reg == $past(pcn_reg) + 8'h01)
      else $error("cylinder counter did not advance inward");
   AST_EC_TRK0: assert property (
      (in_ev && o_rel && !dir_reg && trk0_s && !hit_w && !imp_reg)
      |=> ec_reg && se_reg && sk_idle)
      else $error("outward step past track zero not flagged");
   AST_RECAL_MAX: assert property (
      o_rec |-> steps_reg <= `FDTC_RECAL_MAX)
      else $error("recalibrate stepped more than allowed");
   AST_SEEK_END: assert property (
      (in_ev && o_seek && pcn_reg == tgt_reg && !imp_reg)
      |=> se_reg && int_reg && sk_idle)
      else $error("seek match did not end the command");
   AST_POLL_HOLD: assert property (
      (poll_reg && head_reg) |=> poll_reg)
      else $error("polling ran with head loaded");
   AST_VERSION: assert property (
      (acc && avs_read && sel_vr) |=> avs_readdata[7:0] == VERSION_BYTE
      && !avs_waitrequest)
      else $error("version byte wrong");
   AST_REL_COUNT: assert property (
      (in_ev && o_rel && !fail_w && steps_reg == tgt_reg) |=> sk_idle)
      else $error("relative seek overran its count");

   COV_REL_DONE: cover property (finish && o_rel && hit_w);
   COV_RECAL_FAIL: cover property (finish && o_rec && fail_w && !hit_w);
   COV_POLL_INT: cover property (poll_f);
   COV_EXEC: cover property (x_ent && implied_seek_enable);
endmodule

// file: fdtc_drive_model.sv
// floppy drive model: head position from step pulses, track zero pin
`timescale 1ns/100ps
module fdtc_drive_model (
   input  wire logic clk,
   input  wire logic step_out,
   input  wire logic direction_out,
   output logic      track_zero_input,
   output int        cyl,
   output int        pulses
);
   logic step_q;
   initial
   begin
      step_q = 1'b0;
      cyl = 0;
      pulses = 0;
   end
   // one track per rising step; the head stops hard at track zero
   always @(posedge clk)
   begin
      step_q <= step_out;
      if (step_out && !step_q)
      begin
         pulses <= pulses + 1;
         if (direction_out)
            cyl <= cyl + 1;
         else if (cyl > 0)
            cyl <= cyl - 1;
      end
   end
   // sensor reports the real head, not the controller's counter
   assign track_zero_input = (cyl == 0);
endmodule

// file: tb.sv
// self-checking bench for the drive timing and seek block
`timescale 1ns/100ps
module tb;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic [4:0]  avs_address = 5'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        tz, stp, dir, hl, dma, rfm, irq;
   logic [31:0] rd;
   int          cyl, pulses, fails = 0, checks_done = 0, cycles = 0;

   always #5 clk = ~clk;
   // small timer unit keeps the long seeks short
   fdtc_top #(.UNIT_500K_CYC(20)) DUT (.clk(clk), .srst(srst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .track_zero_input(tz), .step_out(stp), .direction_out(dir),
      .head_load_out(hl), .disk_dma_request(dma),
      .request_for_master(rfm), .disk_interrupt_out(irq));
   fdtc_drive_model drive (.clk(clk), .step_out(stp), .direction_out(dir),
      .track_zero_input(tz), .cyl(cyl), .pulses(pulses));

   task automatic final_report;
      if (fails == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // hang guard: the longest seek needs about 31000 cycles
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 80000)
      begin
         fails++;
         final_report();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // one bus access; request held until waitrequest samples low
   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   // issue a seek command, poll busy until it clears, clear sense
   task automatic seek(input logic [31:0] cmd, output logic [31:0] st);
      int n;
      bus(1'b1, 5'h0C, cmd);
      n = 0;
      do
      begin
         bus(1'b0, 5'h14, 32'h0000_0000);
         n++;
      end
      while (rd[8] !== 1'b0 && n < 20000);
      st = rd;
      chk({31'h0, rd[8]}, 32'h0000_0000);
      chk({31'h0, irq}, 32'h0000_0001);
      bus(1'b1, 5'h14, 32'h0000_0000);
   endtask
   // start a transfer, wait for the request pin of the chosen mode
   task automatic xfer(input logic nd);
      int n;
      bus(1'b1, 5'h00, {16'h0000, nd, 15'h01F1});
      bus(1'b1, 5'h10, 32'h0000_0001);
      n = 0;
      while ((nd ? rfm : dma) !== 1'b1 && n < 400)
      begin
         @(posedge clk);
         n++;
      end
      chk({29'h0, hl, dma, rfm}, {29'h0, 1'b1, !nd, nd});
      chk({31'h0, irq}, {31'h0, nd});
      chk({31'h0, n >= 40}, 32'h0000_0001);
      bus(1'b1, 5'h10, 32'h0000_0002);
      repeat (200) @(posedge clk);
      chk({31'h0, hl}, 32'h0000_0001);
      repeat (200) @(posedge clk);
      chk({31'h0, hl}, 32'h0000_0000);
   endtask
   // implied seek walks the head first; one-byte ack drops the request
   task automatic imp_xfer;
      int n;
      bus(1'b1, 5'h04, 32'h0000_0003);
      bus(1'b1, 5'h10, 32'h0000_0501);
      n = 0;
      while (rfm !== 1'b1 && n < 2000)
      begin
         @(posedge clk);
         n++;
      end
      chk(pulses, 32'h0000_0157);
      bus(1'b0, 5'h14, 32'h0000_0000);
      chk({rd[12], rd[9], rd[7:0]}, 32'h0000_0005);
      bus(1'b1, 5'h10, 32'h0000_0004);
      repeat (2) @(posedge clk);
      chk({31'h0, rfm}, 32'h0000_0000);
      @(posedge clk);
      chk({31'h0, rfm}, 32'h0000_0001);
      bus(1'b1, 5'h10, 32'h0000_0002);
      bus(1'b1, 5'h04, 32'h0000_0002);
   endtask

   initial
   begin
      logic [31:0] st;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      repeat (4) @(posedge clk);
      chk({31'h0, irq}, 32'h0000_0001);
      bus(1'b1, 5'h14, 32'h0000_0000);
      repeat (20) @(posedge clk);
      chk({31'h0, irq}, 32'h0000_0000);
      bus(1'b0, 5'h18, 32'h0000_0000);
      chk(rd, 32'h0000_005A);
      bus(1'b0, 5'h04, 32'h0000_0000);
      chk(rd, 32'h0000_0002);
      bus(1'b0, 5'h00, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      bus(1'b0, 5'h1C, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      bus(1'b1, 5'h04, 32'h0000_FFF2);
      bus(1'b0, 5'h04, 32'h0000_0000);
      chk(rd, 32'h0000_FFF2);
      bus(1'b1, 5'h04, 32'h0000_0002);
      bus(1'b1, 5'h00, 32'h0000_00F0);
      // outward from track zero must refuse to step
      seek(32'h0000_8F02, st);
      chk({st[10:9], 30'h0}, 32'hC000_0000);
      chk(pulses, 32'h0000_0000);
      // count 3 is the target minus the present cylinder 0
      seek(32'h0000_CF03, st);
      chk({st[9], st[7:0]}, 9'h103);
      chk(cyl, 32'h0000_0003);
      seek(32'h0000_CFFF, st);
      chk(st[7:0], 32'h0000_0002);
      chk(pulses, 32'h0000_0102);
      // head now far beyond the recalibrate reach
      seek(32'h0000_0700, st);
      chk(pulses, 32'h0000_0152);
      chk({st[10:9], 30'h0}, 32'hC000_0000);
      xfer(1'b0);
      xfer(1'b1);
      imp_xfer();
      bus(1'b1, 5'h08, 32'h0000_0004);
      bus(1'b0, 5'h08, 32'h0000_0000);
      chk(rd, 32'h0000_0004);
      final_report();
   end
endmodule
